// File: hdl/cidec_core.sv
`timescale 1ns/10ps
// Overview of operation
// - decode all 59 basic instructions across five instruction groups.
// - immediate is two bytes; operand byte follows opcode; address is PC plus 1.
// - direct uses second byte as page-zero address, upper bits zero.
// - extended uses two following bytes as address; three bytes long.
// - taken branch goes to PC plus 2 plus signed byte; not taken adds zero.
// - indexed no offset is one byte; address is index register.
// - indexed 8-bit offset adds unsigned byte to index; two bytes long.
// - indexed 16-bit offset adds two bytes to index; three bytes long.
// - bit set 10+2n, clear 11+2n, page-zero address, 2 bytes, 7 cycles.
// - bit test branch 2n/01+2n, three bytes, bit to carry, 10 cycles.
// - bit manipulation addresses stay within the first 256 bytes.
// - implied instructions are one byte with no address or operand fetch.
// - register/memory opcodes and cycle counts follow the column layout.
// - jumps have no immediate form; subroutine jump takes 7,8,7,8,9 cycles.
// - read/modify/write reads, modifies, writes back; cycles 4,4,6,6,7.
// - test-negative-zero reads its operand but skips the write-back.
// - relative branches 20..2F take 2 bytes, 4 cycles; AD takes 8.
// - 2E branches on interrupt pin low, 2F on pin high.
// - 2C branches on mask clear, 2D on mask set.
// - 24 branches on carry clear, 25 on carry set.
// - all addresses and branch targets are 11 bits wide.
// - stack pointer loads 07F on reset and on the reinit opcode.
module cidec_core (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] byte1_i,
	input wire logic [7:0] byte2_i,
	input wire logic [10:0] pc_i,
	input wire cidec_pkg::cidec_cpu_s cpu_i,
	input wire logic irq_pin_i,
	output logic done_o,
	output cidec_pkg::cidec_decode_s decode_o,
	output logic [10:0] eff_addr_o,
	output logic [10:0] next_pc_o,
	output logic [2:0] bit_sel_o,
	output logic branch_taken_o,
	output logic carry_load_o,
	output logic carry_val_o,
	output logic mem_read_o,
	output logic mem_write_o,
	output logic [10:0] sp_o
);
	import cidec_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// condition evaluation for the 20..2F row; bit tests use the tested bit instead
	function automatic logic br_cond(input logic [3:0] lo, input cidec_cpu_s c, input logic pin);
		logic r;
		r = 1'b0;
		unique case (lo[3:1])
			3'd0: r = 1'b1;
			3'd1: r = ~(c.carry | c.zero);
			3'd2: r = ~c.carry;
			3'd3: r = ~c.zero;
			3'd4: r = ~c.half;
			3'd5: r = ~c.neg;
			3'd6: r = ~c.irq_mask;
			3'd7: r = ~pin;
		endcase
		br_cond = lo[0] ? ~r : r;
	endfunction : br_cond

	// pin passes three flops; a change counts once stages two and three agree
	logic [2:0] pin_sync_ff;
	logic pin_ff;
	logic nxt_pin;

	// ------------------------------------------------------------
	// opcode classification
	// ------------------------------------------------------------
	wire logic [3:0] hi = opcode_i[7:4];
	wire logic [3:0] lo = opcode_i[3:0];
	wire logic is_btb = (hi == 4'h0);
	wire logic is_bsc = (hi == 4'h1);
	wire logic is_rel = (hi == 4'h2) || (opcode_i == OP_BSR);
	wire logic is_rmw = (hi >= 4'h3) && (hi <= 4'h7);
	wire logic is_ctl = (hi == 4'h8) || (hi == 4'h9);
	wire logic is_rm = (hi >= 4'ha) && (opcode_i != OP_BSR);
	wire logic rm_store = (lo == 4'h7) || (lo == 4'hf);
	wire logic rm_jump = (lo == LO_JMP) || (lo == LO_JSR);
	// undefined holes of the map; keeps count at the 59 basic instructions
	wire logic rm_bad = (hi == 4'ha) && (rm_store || rm_jump);
	wire logic rmw_bad = (lo == 4'h1) || (lo == 4'h2) || (lo == 4'h5) || (lo == 4'hb) || (lo == 4'he);
	wire logic ctl_ok = (opcode_i == 8'h80) || (opcode_i == 8'h81) || (opcode_i == 8'h83)
		|| (opcode_i == 8'h97) || ((hi == 4'h9) && (lo >= 4'h8) && (lo <= 4'hd)) || (opcode_i == 8'h9f);
	wire logic op_ok = is_btb || is_bsc || is_rel || (is_rmw && !rmw_bad) || (is_ctl && ctl_ok)
		|| (is_rm && !rm_bad);

	// ------------------------------------------------------------
	// addressing mode, length and cycles
	// ------------------------------------------------------------
	cidec_decode_s dec;
	always_comb begin
		dec = '0;
		dec.valid = op_ok;
		dec.write_back = 1'b0;
		if (is_btb) begin
			dec.amode = AM_BTB;
			dec.length = 2'd3;
			dec.cycles = CYC_BIT_BRANCH;
		end else if (is_bsc) begin
			dec.amode = AM_BSC;
			dec.length = 2'd2;
			dec.cycles = CYC_BIT_SETCLR;
			dec.write_back = 1'b1;
		end else if (is_rel) begin
			dec.amode = AM_REL;
			dec.length = 2'd2;
			dec.cycles = (opcode_i == OP_BSR) ? CYC_BSR : CYC_REL;
		end else if (is_rmw) begin
			dec.write_back = (lo != HI_RMW_TEST);
			unique case (hi)
				4'h3: begin dec.amode = AM_DIR; dec.length = 2'd2; dec.cycles = 4'd6; end
				4'h6: begin dec.amode = AM_IX1; dec.length = 2'd2; dec.cycles = 4'd7; end
				4'h7: begin dec.amode = AM_IX0; dec.length = 2'd1; dec.cycles = 4'd6; end
				default: begin dec.amode = AM_IMPLIED; dec.length = 2'd1; dec.cycles = 4'd4; end
			endcase
		end else if (is_ctl) begin
			dec.amode = AM_IMPLIED;
			dec.length = 2'd1;
			unique case (opcode_i)
				8'h80: dec.cycles = 4'd9;
				8'h81: dec.cycles = 4'd6;
				8'h83: dec.cycles = 4'd11;
				default: dec.cycles = 4'd2;
			endcase
		end else begin
			// register/memory columns A..F; stores add one, jumps shift per lo
			unique case (hi)
				4'ha: begin dec.amode = AM_IMM; dec.length = 2'd2; dec.cycles = 4'd2; end
				4'hb: begin dec.amode = AM_DIR; dec.length = 2'd2; dec.cycles = 4'd4; end
				4'hc: begin dec.amode = AM_EXT; dec.length = 2'd3; dec.cycles = 4'd5; end
				4'hd: begin dec.amode = AM_IX2; dec.length = 2'd3; dec.cycles = 4'd6; end
				4'he: begin dec.amode = AM_IX1; dec.length = 2'd2; dec.cycles = 4'd5; end
				default: begin dec.amode = AM_IX0; dec.length = 2'd1; dec.cycles = 4'd4; end
			endcase
			if (rm_store)
				dec.cycles = dec.cycles + 4'd1;
			else if (lo == LO_JMP)
				dec.cycles = dec.cycles - 4'd1;
			else if (lo == LO_JSR)
				dec.cycles = dec.cycles + 4'd3;
		end
	end

	// ------------------------------------------------------------
	// effective address and branch target
	// ------------------------------------------------------------
	wire logic [10:0] wide_op = {byte1_i[2:0], byte2_i};
	wire logic [10:0] idx_ext = {3'b000, cpu_i.idx};
	wire logic [7:0] disp = is_btb ? byte2_i : byte1_i;
	wire logic [10:0] disp_ext = {{3{disp[7]}}, disp};
	wire logic bit_val = byte2_i[opcode_i[3:1]];
	wire logic take = is_btb ? (bit_val ^ opcode_i[0]) :
		(opcode_i == OP_BSR) ? 1'b1 : br_cond(lo, cpu_i, pin_ff);
	wire logic [10:0] len_ext = {9'd0, dec.length};
	wire logic [10:0] fall_pc = pc_i + len_ext;
	// btb is three bytes: target counts from end of instruction
	wire logic [10:0] br_base = is_btb ? fall_pc : (pc_i + BR_BIAS);
	wire logic [10:0] br_target = br_base + (take ? disp_ext : 11'h000);
	logic [10:0] ea;
	always_comb begin
		unique case (dec.amode)
			AM_IMM: ea = pc_i + 11'h001;
			AM_DIR, AM_BSC, AM_BTB: ea = {3'b000, byte1_i};
			AM_EXT: ea = wide_op;
			AM_IX0: ea = idx_ext;
			AM_IX1: ea = idx_ext + {3'b000, byte1_i};
			AM_IX2: ea = idx_ext + wide_op;
			default: ea = 11'h000;
		endcase
	end
	wire logic is_jmp = is_rm && rm_jump;
	wire logic [10:0] nxt_pc = (is_rel || is_btb) ? br_target : is_jmp ? ea : fall_pc;
	wire logic rd = dec.valid && (dec.amode != AM_IMPLIED) && (dec.amode != AM_REL)
		&& (dec.amode != AM_IMM) && !is_jmp && !(is_rm && rm_store);
	wire logic wr = dec.valid && ((is_rmw && dec.write_back && dec.amode != AM_IMPLIED)
		|| is_bsc || (is_rm && rm_store));
	wire logic sp_reinit = instr_valid_i && (opcode_i == OP_STACK_REINIT);

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	// pin synchroniser; only stages two and three are compared
	assign nxt_pin = (pin_sync_ff[1] == pin_sync_ff[2]) ? pin_sync_ff[2] : pin_ff;
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pin_sync_ff <= 3'b111;
			pin_ff <= 1'b1;
		end else begin
			pin_sync_ff <= {pin_sync_ff[1:0], irq_pin_i};
			pin_ff <= nxt_pin;
		end
	end

	// results latch one cycle after the instruction is presented
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			done_o <= 1'b0;
			decode_o <= '0;
			eff_addr_o <= 11'h000;
			next_pc_o <= PC_RESET;
			bit_sel_o <= 3'd0;
			branch_taken_o <= 1'b0;
			carry_load_o <= 1'b0;
			carry_val_o <= 1'b0;
			mem_read_o <= 1'b0;
			mem_write_o <= 1'b0;
		end else begin
			done_o <= instr_valid_i;
			decode_o <= dec;
			eff_addr_o <= ea;
			next_pc_o <= nxt_pc;
			bit_sel_o <= opcode_i[3:1];
			branch_taken_o <= instr_valid_i && (is_rel || is_btb) && take;
			carry_load_o <= instr_valid_i && is_btb;
			carry_val_o <= bit_val;
			mem_read_o <= instr_valid_i && rd;
			mem_write_o <= instr_valid_i && wr;
		end
	end

	// stack pointer: only the reset value and reinit are owned here
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i)
			sp_o <= SP_RESET;
		else if (sp_reinit)
			sp_o <= SP_RESET;
	end
endmodule : cidec_core

// File: hdl/cidec_pkg.sv
package cidec_pkg;
	// ------------------------------------------------------------
	// widths and fixed values
	// ------------------------------------------------------------
	localparam int ADDR_W = 11;
	localparam logic [10:0] SP_RESET = 11'h07f;
	localparam logic [10:0] PC_RESET = 11'h000;
	localparam logic [7:0] ACC_RESET = 8'h00;
	localparam logic [7:0] IDX_RESET = 8'h00;
	localparam logic [10:0] BR_BIAS = 11'h002;
	localparam int BASIC_INSTR_COUNT = 59;
	// ------------------------------------------------------------
	// opcode anchors
	// ------------------------------------------------------------
	localparam logic [7:0] OP_BR_FIRST = 8'h20;
	localparam logic [7:0] OP_BR_CC = 8'h24;
	localparam logic [7:0] OP_BR_CS = 8'h25;
	localparam logic [7:0] OP_BR_MC = 8'h2c;
	localparam logic [7:0] OP_BR_MS = 8'h2d;
	localparam logic [7:0] OP_BR_IL = 8'h2e;
	localparam logic [7:0] OP_BR_IH = 8'h2f;
	localparam logic [7:0] OP_BSR = 8'had;
	localparam logic [7:0] OP_STACK_REINIT = 8'h9c;
	localparam logic [3:0] HI_RMW_TEST = 4'hd;
	localparam logic [3:0] LO_JMP = 4'hc;
	localparam logic [3:0] LO_JSR = 4'hd;
	// ------------------------------------------------------------
	// cycle counts
	// ------------------------------------------------------------
	localparam logic [3:0] CYC_BIT_SETCLR = 4'h7;
	localparam logic [3:0] CYC_BIT_BRANCH = 4'ha;
	localparam logic [3:0] CYC_REL = 4'h4;
	localparam logic [3:0] CYC_BSR = 4'h8;

	typedef enum logic [3:0] {
		AM_IMPLIED, AM_IMM, AM_DIR, AM_EXT, AM_REL,
		AM_IX0, AM_IX1, AM_IX2, AM_BSC, AM_BTB
	} cidec_amode_e;

	// decoded instruction shape
	typedef struct packed {
		cidec_amode_e amode;
		logic [1:0] length;
		logic [3:0] cycles;
		logic write_back;
		logic valid;
	} cidec_decode_s;

	// programmer-visible state offered by the core around the decoder
	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] idx;
		logic carry;
		logic irq_mask;
		logic zero;
		logic neg;
		logic half;
	} cidec_cpu_s;
endpackage : cidec_pkg

// File: dv/cidec_checker.sv
`timescale 1ns/10ps
module cidec_checker (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic instr_valid_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] byte1_i,
	input wire logic [7:0] byte2_i,
	input wire logic [10:0] pc_i,
	input wire cidec_pkg::cidec_cpu_s cpu_i,
	input wire logic irq_pin_i,
	input wire logic done_o,
	input wire cidec_pkg::cidec_decode_s decode_o,
	input wire logic [10:0] eff_addr_o,
	input wire logic [10:0] next_pc_o,
	input wire logic [2:0] bit_sel_o,
	input wire logic branch_taken_o,
	input wire logic carry_load_o,
	input wire logic carry_val_o,
	input wire logic mem_read_o,
	input wire logic mem_write_o,
	input wire logic [10:0] sp_o
);
	import cidec_pkg::*;
	// ----
	// expected values from the request side
	// ----
	wire act = rst_n_i && instr_valid_i;
	wire [3:0] hi = opcode_i[7:4];
	wire [10:0] ext_w = {byte1_i[2:0], byte2_i};
	wire [10:0] ix0_w = {3'h0, cpu_i.idx};
	wire [10:0] ix1_w = {3'h0, cpu_i.idx} + {3'h0, byte1_i};
	wire [10:0] rel_w = pc_i + 11'h002 + {{3{byte1_i[7]}}, byte1_i};
	wire bt_w = byte2_i[opcode_i[3:1]];
	wire tst_w = opcode_i[3:0] == 4'hd && hi >= 4'h3 && hi <= 4'h7;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	done_pulse_a: assert property ($past(rst_n_i) |-> done_o == $past(instr_valid_i))
		else $error("done does not follow valid");
	sp_fixed_a: assert property (sp_o == SP_RESET)
		else $error("stack pointer moved");
	direct_addr_a: assert property (act && opcode_i == 8'hb6 |=> eff_addr_o == {3'h0, $past(byte1_i)})
		else $error("direct address wrong");
	ext_addr_a: assert property ($past(act && hi == 4'hc) |-> eff_addr_o == $past(ext_w))
		else $error("extended address wrong");
	ix_plain_a: assert property ($past(act && hi == 4'hf) |-> eff_addr_o == $past(ix0_w))
		else $error("indexed address wrong");
	ix_byte_a: assert property ($past(act && hi == 4'he) |-> eff_addr_o == $past(ix1_w))
		else $error("offset indexed address wrong");
	rel_target_a: assert property (act && opcode_i == 8'h20 |=> next_pc_o == $past(rel_w))
		else $error("branch target wrong");
	test_nowrite_a: assert property (act && tst_w |=> !mem_write_o && !decode_o.write_back)
		else $error("test wrote back");
	bit_setclr_a: assert property (act && hi == 4'h1 |=> decode_o.cycles == 4'h7 && eff_addr_o[10:8] == 3'h0)
		else $error("bit set or clear shape wrong");
	bit_carry_a: assert property (act && hi == 4'h0 |=> carry_load_o && carry_val_o == $past(bt_w))
		else $error("tested bit not sent to carry");
	implied_one_a: assert property (act && opcode_i == 8'h9d |=> decode_o.length == 2'h1 && !mem_read_o)
		else $error("implied shape wrong");
	cover property (act && hi == 4'h0);
	cover property (branch_taken_o);
	cover property (act && tst_w);
endmodule : cidec_checker

// File: dv/cidec_prog_mem.sv
`timescale 1ns/10ps
// program memory: opcode and the two bytes after it, read without delay
module cidec_prog_mem (
	input wire logic [10:0] pc_i,
	output logic [7:0] opcode_o,
	output logic [7:0] byte1_o,
	output logic [7:0] byte2_o
);
	logic [7:0] m [2048];
	// address wraps at 11 bits like the core's counter
	assign opcode_o = m[pc_i];
	assign byte1_o = m[pc_i + 11'h001];
	assign byte2_o = m[pc_i + 11'h002];
endmodule : cidec_prog_mem

// File: dv/cidec_core_tb.sv
`timescale 1ns/10ps
module cidec_core_tb;
	import cidec_pkg::*;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [10:0] pc_i = 11'h000;
	logic irq_pin_i = 1'b0;
	cidec_cpu_s cpu_i = '0;
	logic [7:0] op_w, b1_w, b2_w;
	logic done_o, branch_taken_o, carry_load_o, carry_val_o, mem_read_o, mem_write_o;
	cidec_decode_s decode_o;
	logic [10:0] eff_addr_o, next_pc_o, sp_o;
	logic [2:0] bit_sel_o;
	int bad_count = 0;
	int n_checks = 0;
	// free-running core clock
	always #5 core_clk_i = ~core_clk_i;
	cidec_prog_mem pm (.pc_i(pc_i), .opcode_o(op_w), .byte1_o(b1_w), .byte2_o(b2_w));
	cidec_core dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .opcode_i(op_w),
		.byte1_i(b1_w), .byte2_i(b2_w), .pc_i(pc_i), .cpu_i(cpu_i), .irq_pin_i(irq_pin_i), .done_o(done_o),
		.decode_o(decode_o), .eff_addr_o(eff_addr_o), .next_pc_o(next_pc_o), .bit_sel_o(bit_sel_o),
		.branch_taken_o(branch_taken_o), .carry_load_o(carry_load_o), .carry_val_o(carry_val_o),
		.mem_read_o(mem_read_o), .mem_write_o(mem_write_o), .sp_o(sp_o));
	// ----
	// helpers
	// ----
	task chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// valid stays up so back-to-back requests never toggle it twice in one step
	task issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2, input logic [10:0] pc);
		pm.m[pc] = op;
		pm.m[pc + 11'h001] = b1;
		pm.m[pc + 11'h002] = b2;
		pc_i = pc;
		instr_valid_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		chk(24'(done_o), 24'h1);
	endtask : issue
	task fin(input string s);
		instr_valid_i = 1'b0;
		@(posedge core_clk_i);
		#1;
		$display("%s done", s);
	endtask : fin
	// ----
	// scenarios
	// ----
	task t_reset;
		chk(24'({done_o, sp_o}), 24'h07f);
		issue(8'h9c, 8'h00, 8'h00, 11'h040);
		chk(24'(sp_o), 24'h07f);
		issue(8'h31, 8'h00, 8'h00, 11'h041);
		chk(24'(decode_o.valid), 24'h0);
		fin("reset");
	endtask : t_reset
	task t_table;
		logic [15:0] tab [26];
		tab = '{16'ha622, 16'hb624, 16'hc635, 16'hf614, 16'he625, 16'hd636, 16'hbd27, 16'hcd38, 16'hfd17,
			16'hed28, 16'hdd39, 16'h4c14, 16'h5c14, 16'h3c26, 16'h7c16, 16'h6c27, 16'h1027, 16'h1f27, 16'h003a,
			16'h0f3a, 16'h2024, 16'h2f24, 16'had28, 16'h9c12, 16'h9d12, 16'h3d26};
		foreach (tab[i]) begin
			issue(tab[i][15:8], 8'h12, 8'h34, 11'h100);
			chk(24'({decode_o.valid, decode_o.length, decode_o.cycles}), 24'({1'b1, tab[i][5:4], tab[i][3:0]}));
		end
		issue(8'h3c, 8'h12, 8'h34, 11'h100);
		chk(24'(decode_o.write_back), 24'h1);
		issue(8'h3d, 8'h12, 8'h34, 11'h100);
		chk(24'({decode_o.write_back, mem_write_o}), 24'h0);
		fin("table");
	endtask : t_table
	task t_modes;
		logic [23:0] tab [5];
		tab = '{24'hb600ff, 24'hc60745, 24'hf600ff, 24'he601fe, 24'hd60044};
		cpu_i.idx = 8'hff;
		foreach (tab[i]) begin
			issue(tab[i][23:16], 8'hff, 8'h45, 11'h200);
			chk(24'(eff_addr_o), 24'(tab[i][15:0]));
		end
		issue(8'ha6, 8'h55, 8'h00, 11'h200);
		chk(24'(next_pc_o), 24'h202);
		fin("modes");
	endtask : t_modes
	task t_branch;
		logic [7:0] ops [6];
		ops = '{8'h24, 8'h25, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
		for (int v = 0; v < 2; v++) begin
			cpu_i.carry = v[0];
			cpu_i.irq_mask = v[0];
			irq_pin_i = v[0];
			repeat (4) @(posedge core_clk_i);
			#1;
			foreach (ops[i]) begin
				issue(ops[i], 8'hf0, 8'h00, 11'h010);
				chk(24'({branch_taken_o, next_pc_o}), (v[0] == ops[i][0]) ? 24'h802 : 24'h012);
			end
		end
		issue(8'h20, 8'h7f, 8'h00, 11'h7f8);
		chk(24'(next_pc_o), 24'h079);
		fin("branch");
	endtask : t_branch
	task t_bits;
		for (int n = 0; n < 8; n++) begin
			issue(8'h10 + 8'(2 * n), 8'ha5, 8'h00, 11'h300);
			chk(24'({bit_sel_o, eff_addr_o}), 24'({n[2:0], 11'h0a5}));
			issue(8'h11 + 8'(2 * n), 8'ha5, 8'h00, 11'h300);
			chk(24'({bit_sel_o, decode_o.length}), 24'({n[2:0], 2'h2}));
		end
		issue(8'h0e, 8'h40, 8'h80, 11'h300);
		chk(24'({carry_load_o, carry_val_o, bit_sel_o, branch_taken_o, next_pc_o}), 24'h01fa83);
		issue(8'h0f, 8'h40, 8'h80, 11'h300);
		chk(24'({carry_load_o, carry_val_o, bit_sel_o, branch_taken_o, next_pc_o}), 24'h01f303);
		chk(24'(eff_addr_o), 24'h040);
		issue(8'h00, 8'h40, 8'h05, 11'h300);
		chk(24'({carry_val_o, bit_sel_o, branch_taken_o, next_pc_o}), 24'h008b08);
		fin("bits");
	endtask : t_bits
	// ----
	// sequence, watchdog and verdict
	// ----
	initial begin
		repeat (6) @(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		t_reset;
		t_table;
		t_modes;
		t_branch;
		t_bits;
		results;
	end
	// whole run is under 90 cycles; this leaves wide margin
	initial begin
		#100000;
		bad_count++;
		results;
	end
	task results;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
endmodule : cidec_core_tb
bind cidec_core cidec_checker u_chk (.*);
